// >>> verilog/clkfo_top.v
/*
 * Clock fanout top: selects the primary differential or the test/reference
 * clock, gates it with a falling-edge synchronised enable and copies it to
 * twelve outputs with a direct three-state control.
 * A small one-hot phase machine turns the sampled enable into the output
 * pattern, so the gate can only open or close while the selected clock is low.
 * Assumes all pins but output_hiz_n are sampled synchronously to sys_clk and that pull-ups on
 * the control pins are provided by the pad ring or the surrounding wiring.
 */
// Operation
// [RULE_01] Select low routes differential primary clock, high routes test clock.
// [RULE_02] Selected clock drives all twelve outputs together, indexed eleven to zero.
// [RULE_03] Enable high lets outputs toggle; enable low holds every output low.
// [RULE_04] Enable is sampled on the selected clock's falling edge only.
// [RULE_05] Enable changes never create glitches or runt pulses on outputs.
// [RULE_06] Three-state control low floats all outputs; high drives them.
// [RULE_07] Select, enable and three-state control default high when undriven.
// [RULE_08] Three-state control acts directly and overrides enabled and parked states.
`timescale 1ns/1ps
`default_nettype none
`include "clkfo_defs.vh"

module clkfo_top (
    input  wire                       sys_clk,
    input  wire                       rst,
    input  wire                       clk_en,
    input  wire                       diff_clk_in_p,
    input  wire                       diff_clk_in_n,
    input  wire                       test_ref_clk_in,
    input  wire                       ref_clk_select,
    input  wire                       sync_out_enable,
    input  wire                       output_hiz_n,
    output wire [`CLKFO_NUM_OUT-1:0]  q_out,
    output wire [`CLKFO_NUM_OUT-1:0]  q_oe
);

    // One-hot phases of the output gate
    localparam [2:0] ST_PARKED   = 3'h1;
    localparam [2:0] ST_RUN_LOW  = 3'h2;
    localparam [2:0] ST_RUN_HIGH = 3'h4;

    // Selection path
    wire                      primary_level;
    reg                       sel_level;
    wire                      sel_low;

    // Enable and gate phase
    wire                      next_oe;
    reg  [2:0]                gate_state;
    reg  [2:0]                next_gate_state;

    // Output path
    wire                      next_q;
    reg  [`CLKFO_NUM_OUT-1:0] q;

    // Differential primary: high only when p above n (undriven p up, n down)
    assign primary_level = diff_clk_in_p & ~diff_clk_in_n;   // [RULE_07]

    // Reference clock selection; anything but primary picks the test clock
    always @* begin
        case (ref_clk_select)
            `CLKFO_SEL_PRIMARY: begin
                sel_level = primary_level;                  // [RULE_01]
            end
            default: begin
                sel_level = test_ref_clk_in;                // [RULE_01]
            end
        endcase
    end

    // Selected clock low: the only time the gate may open or close
    assign sel_low = ~sel_level;                            // [RULE_05]

    // Falling-edge synchronised enable
    clkfo_oe_sync clkfo_oe_sync_inst (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .clk_en          (clk_en),
        .clk_level       (sel_level),
        .sync_out_enable (sync_out_enable),
        .next_oe         (next_oe)
    );

    // Gate phase: parked stays parked while high, so no runt on opening
    always @* begin
        next_gate_state = ST_PARKED;
        case (gate_state)
            ST_PARKED: begin
                if (sel_low && next_oe) begin
                    next_gate_state = ST_RUN_LOW;           // [RULE_03] [RULE_05]
                end else begin
                    next_gate_state = ST_PARKED;
                end
            end
            ST_RUN_LOW, ST_RUN_HIGH: begin
                if (!sel_low) begin
                    next_gate_state = ST_RUN_HIGH;
                end else if (next_oe) begin
                    next_gate_state = ST_RUN_LOW;
                end else begin
                    next_gate_state = ST_PARKED;            // [RULE_03] [RULE_05]
                end
            end
            default: begin
                next_gate_state = ST_PARKED;
            end
        endcase
    end

    // Gate phase register, frozen with the clock enable
    always @(posedge sys_clk) begin
        if (rst) begin
            gate_state <= `CLKFO_GATE_RST;
        end else if (clk_en) begin
            gate_state <= next_gate_state;
        end
    end

    // Gated clock level: high only in the running high phase
    assign next_q = (next_gate_state == ST_RUN_HIGH);       // [RULE_03] [RULE_05]

    // One output stage per line, all fed from the same gated level
    genvar i;
    generate
        for (i = 0; i < `CLKFO_NUM_OUT; i = i + 1) begin : g_out
            always @(posedge sys_clk) begin
                if (rst) begin
                    q[i] <= `CLKFO_Q_RST;
                end else if (clk_en) begin
                    q[i] <= next_q;                         // [RULE_02]
                end
            end
            // Direct, unsynchronised three-state control
            assign q_oe[i] = output_hiz_n;                  // [RULE_06] [RULE_08]
        end
    endgenerate

    assign q_out = q;

endmodule
`default_nettype wire

// >>> verilog/clkfo_defs.vh
/*
 * Constants of the clock fanout block: output count and reset values.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef CLKFO_DEFS_VH
`define CLKFO_DEFS_VH

// Number of clock outputs in the group
`define CLKFO_NUM_OUT       12
// Reset value of the latched output enable (parked until first falling edge)
`define CLKFO_OE_RST       1'b0
// Reset value of the previous selected-clock level
`define CLKFO_LEVEL_RST    1'b0
// Reset value of each clock output level
`define CLKFO_Q_RST        1'b0
// Select level that picks the differential primary input
`define CLKFO_SEL_PRIMARY  1'b0
// Reset phase of the output gate: parked low (one-hot)
`define CLKFO_GATE_RST     3'h1

`endif

// >>> verilog/clkfo_oe_sync.v
/*
 * Output-enable synchroniser: tracks the selected clock level, finds its
 * falling edge and latches the output enable only on that edge.
 * Assumes the clock level and enable are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clkfo_defs.vh"

module clkfo_oe_sync (
    input  wire sys_clk,
    input  wire rst,
    input  wire clk_en,
    input  wire clk_level,
    input  wire sync_out_enable,
    output wire next_oe
);

    reg  prev_level;
    reg  oe_latched;
    wire falling;

    // Falling edge of the selected clock
    assign falling = prev_level & ~clk_level;
    // Enable only changes from the value sampled at a falling edge
    assign next_oe = falling ? sync_out_enable : oe_latched;   // [RULE_04]

    // Level history and enable latch
    always @(posedge sys_clk) begin
        if (rst) begin
            prev_level <= `CLKFO_LEVEL_RST;
            oe_latched <= `CLKFO_OE_RST;
        end else if (clk_en) begin
            prev_level <= clk_level;
            oe_latched <= next_oe;                              // [RULE_04]
        end
    end

endmodule
`default_nettype wire

// >>> bench/clkfo_src.sv
/* Clock source model: differential pair and test clock. Assumes sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module clkfo_src (
    input  wire logic sys_clk,
    output logic      p = 1'h0,
    output logic      n = 1'h1,
    output logic      t = 1'h0
);
    // Test clock toggles each cycle, pair flips at random
    always @(posedge sys_clk) begin
        t <= ~t;
        if ($urandom % 2) begin
            p <= ~p;
            n <= p;
        end
    end
endmodule
`default_nettype wire

// >>> bench/clkfo_props.sv
/* Fanout checker on top ports. Assumes a bind from the bench. */
`timescale 1ns/1ps
`default_nettype none
module clkfo_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        diff_clk_in_p,
    input wire logic        diff_clk_in_n,
    input wire logic        test_ref_clk_in,
    input wire logic        ref_clk_select,
    input wire logic        sync_out_enable,
    input wire logic        output_hiz_n,
    input wire logic [11:0] q_out,
    input wire logic [11:0] q_oe
);
    wire s = ref_clk_select ? test_ref_clk_in : diff_clk_in_p & ~diff_clk_in_n;
    reg v = 1'h0;
    reg e = 1'h0;
    // Mirror of the latched enable
    always @(posedge sys_clk) begin
        if (rst) begin
            v <= 1'h0;
            e <= 1'h0;
        end else if (clk_en) begin
            v <= s;
            if (v & ~s) e <= sync_out_enable;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_fall; clk_en && v && !s; endsequence
    property p_tst;
        clk_en && ref_clk_select && e |=> q_out[0] == $past(test_ref_clk_in);
    endproperty
    a_tst: assert property (p_tst) else $error("tst");
    property p_grp; q_out == {12{q_out[0]}}; endproperty
    a_grp: assert property (p_grp) else $error("grp");
    property p_park; clk_en && !e |=> !q_out[0]; endproperty
    a_park: assert property (p_park) else $error("park");
    property p_samp; s_fall ##0 sync_out_enable ##1 clk_en && s |=> q_out[0]; endproperty
    a_samp: assert property (p_samp) else $error("samp");
    property p_hold; s_fall ##0 !sync_out_enable |=> !q_out[0] [*2]; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rise; $rose(q_out[0]) |-> $past(s); endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_drop; $fell(q_out[0]) && !$past(rst) |-> !$past(s); endproperty
    a_drop: assert property (p_drop) else $error("drop");
    property p_hiz; q_oe == {12{output_hiz_n}}; endproperty
    a_hiz: assert property (p_hiz) else $error("hiz");
endmodule
`default_nettype wire

// >>> bench/clock_fanout_select_gate_tb.sv
/* Fanout bench: random controls, source model, mirror. Assumes the design. */
`timescale 1ns/1ps
`default_nettype none
module clock_fanout_select_gate_tb;
    logic       sys_clk   = 0;
    logic       rst       = 1;
    logic       ce        = 1;
    logic       sl        = 1;
    logic       oe        = 1;
    logic       hz        = 1;
    logic       dz        = 0;
    logic       pv        = 0;
    logic       eo        = 0;
    logic       eq        = 0;
    wire        p, n, t;
    tri1        sl_w, oe_w, hz_w;
    wire [11:0] q, qe;
    int         n_errors  = 0;
    int         tests_run = 0;
    // Undriven control pins float to their pull-up level
    assign sl_w = dz ? 1'bz : sl;
    assign oe_w = dz ? 1'bz : oe;
    assign hz_w = dz ? 1'bz : hz;
    // Expected selected level; an undriven select reads high
    function automatic logic lv();
        lv = (sl | dz) ? t : p & ~n;
    endfunction
    clkfo_src clkfo_src_inst (.sys_clk(sys_clk), .p(p), .n(n), .t(t));
    clkfo_top clkfo_top_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(ce), .diff_clk_in_p(p),
        .diff_clk_in_n(n), .test_ref_clk_in(t), .ref_clk_select(sl_w),
        .sync_out_enable(oe_w), .output_hiz_n(hz_w), .q_out(q), .q_oe(qe));
    initial forever #20 sys_clk = ~sys_clk;
    // Expected output level
    always @(posedge sys_clk) begin
        if (rst) begin
            {pv, eo, eq} <= 3'h0;
        end else if (ce) begin
            pv <= lv();
            eq <= lv() & eo;
            if (pv & ~lv()) eo <= oe | dz;
        end
    end
    task chk(input logic [11:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %0t %h %h", $time, s, e);
        end
    endtask
    task results;
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("[ PASS ]"); else $display("[ FAIL ]");
        $finish;
    endtask
    // Phases: primary, test clock, mid-run reset, three-state, undriven controls
    initial begin
        void'($urandom(39));
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        for (int k = 0; k < 5; k++) begin
            repeat (400) begin
                @(posedge sys_clk);
                ce <= $urandom % 8 != 0;
                sl <= k[0];
                if ($urandom % 16 == 0) oe <= ~oe;
                hz <= k == 3 ? $urandom % 2 : 1'h1;
                rst <= k == 2 && $urandom % 50 == 0;
                dz <= k == 4;
                @(negedge sys_clk);
                chk(q, {12{eq}});
                chk(qe, {12{hz | dz}});
            end
            $display("test %0d done", k);
        end
        results();
    end
endmodule
bind clkfo_top clkfo_props clkfo_props_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .diff_clk_in_p(diff_clk_in_p), .diff_clk_in_n(diff_clk_in_n), .q_out(q_out), .q_oe(q_oe),
    .test_ref_clk_in(test_ref_clk_in), .ref_clk_select(ref_clk_select),
    .sync_out_enable(sync_out_enable), .output_hiz_n(output_hiz_n));
`default_nettype wire
